// [inc/interval_timer_pkg.sv]
// constants and types shared by the interval timer files
`default_nettype none
package interval_timer_pkg;
    localparam logic [7:0] ADDR_TIMER_COMMAND = 8'h10;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h14;
    localparam logic [7:0] ADDR_COUNT_HIGH_WAVE = 8'h15;
    localparam int COUNT_WIDTH = 14;
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 6;
    localparam int WAVE_MSB = 7;
    localparam int WAVE_LSB = 6;
    localparam int HIGH_COUNT_MSB = 5;
    localparam int TICK_DIVIDE = 10;
    localparam int MASTER_CLOCK_KHZ = 3072;
    localparam int TICK_RATE_HZ = 307200;
    localparam int SYS_CLOCK_MHZ = 250;
    localparam int MASTER_DIVIDE = (SYS_CLOCK_MHZ * 1000) / MASTER_CLOCK_KHZ;
    localparam logic [13:0] COUNT_RESET = 14'h0000;
    localparam logic [13:0] COUNT_MIN = 14'h0002;
    localparam logic [13:0] COUNT_MAX = 14'h3FFF;
    typedef enum logic [1:0]
    {
        CMD_NOP,
        CMD_STOP,
        CMD_STOP_AT_TC,
        CMD_START
    } timer_cmd_t;
    typedef enum logic [1:0]
    {
        WAVE_SINGLE_SQUARE,
        WAVE_CONT_SQUARE,
        WAVE_SINGLE_PULSE,
        WAVE_RELOAD_PULSE
    } wave_mode_t;
endpackage : interval_timer_pkg
`default_nettype wire

// [verilog/divide_by_ten_stage.sv]
// clock-enable divider: one tick every DIVIDE input strobes
`default_nettype none
module divide_by_ten_stage
    import interval_timer_pkg::*;
#(
    parameter int DIVIDE = TICK_DIVIDE
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic strobeIn,
    output logic tickOut
);
    logic [7:0] count_ff;
    logic [7:0] nxt_count;
    logic tick_ff;
    logic nxt_tick;

    always_comb
    begin
        nxt_count = count_ff;
        nxt_tick = 1'b0;
        if (strobeIn)
        begin
            if (count_ff == 8'(DIVIDE - 1))
            begin
                nxt_count = 8'h00;
                nxt_tick = 1'b1;
            end
            else
            begin
                nxt_count = count_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            count_ff <= 8'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            tick_ff <= nxt_tick;
        end
    end

    assign tickOut = tick_ff;
endmodule : divide_by_ten_stage
`default_nettype wire

// [verilog/timer_host_port.sv]
// byte write port: decodes the three timer registers
`default_nettype none
module timer_host_port
    import interval_timer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ioWrite,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioData,
    output logic cmdWrite,
    output logic [1:0] cmdCode,
    output logic [7:0] lowByte,
    output logic [7:0] highByte,
    output logic lengthWrite
);
    logic [7:0] low_ff;
    logic [7:0] nxt_low;
    logic [7:0] high_ff;
    logic [7:0] nxt_high;

    always_comb
    begin
        nxt_low = low_ff;
        nxt_high = high_ff;
        cmdWrite = 1'b0;
        lengthWrite = 1'b0;
        if (ioWrite && ioAddr == ADDR_TIMER_COMMAND)
        begin
            cmdWrite = 1'b1; // (R11)
        end
        else if (ioWrite && ioAddr == ADDR_COUNT_LOW)
        begin
            nxt_low = ioData; // (R12)
        end
        else if (ioWrite && ioAddr == ADDR_COUNT_HIGH_WAVE)
        begin
            nxt_high = ioData; // (R13)
            lengthWrite = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            low_ff <= 8'h00;
            high_ff <= 8'h00;
        end
        else
        begin
            low_ff <= nxt_low;
            high_ff <= nxt_high;
        end
    end

    // only the top two bits steer the timer
    assign cmdCode = ioData[CMD_MSB:CMD_LSB]; // (R19)
    assign lowByte = low_ff;
    assign highByte = high_ff;
endmodule : timer_host_port
`default_nettype wire

// [verilog/programmable_interval_timer.sv]
// interval timer top: count, command modes and output waveforms
//
// Functional notes
// (R1) 14-bit down counter, flags terminal count
// (R2) software loads lengths from 2 to 3FFF
// (R3) command 0 changes nothing
// (R4) command 1 stops a running counter now
// (R5) command 2 stops at next terminal count
// (R6) command 3 loads and starts, or defers
// (R7) wave 0: high first half, low second
// (R8) wave 1: continuous square, reloads each time
// (R9) wave 2: one pulse, no reload
// (R10) wave 3: pulse each terminal count, reload
// (R11) command register at address 10
// (R12) low count byte at address 14
// (R13) high count bits and wave at 15
// (R14) length may be rewritten while counting
// (R15) output feeds host interrupt; count readable
// (R16) tick is master clock divided by ten
// (R17) speaker is timer output AND serial bit
// (R18) single-shot and reload both supported
// (R19) command in top two register bits
// (R20) wave bits 7:6, count bits 5:0
// (R21) reset leaves timer stopped and cleared
`default_nettype none
module programmable_interval_timer
    import interval_timer_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH,
    parameter int MASTER_DIV = MASTER_DIVIDE
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ioWrite,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioData,
    input wire logic processor_serial_out_bit,
    output logic timerOut,
    output logic timerInterrupt,
    output logic speakerDrive,
    output logic running,
    output logic [WIDTH-1:0] currentCount
);
    // ----------------------------------------
    // tick generation
    // ----------------------------------------
    logic [7:0] mdiv_ff;
    logic [7:0] nxt_mdiv;
    logic masterStrobe;
    logic timerTick;
    logic cmdWrite;
    logic lengthWrite;
    logic [1:0] cmdCode;
    logic [7:0] lowByte;
    logic [7:0] highByte;

    // board_master_clock stand-in derived from sys_clk
    always_comb
    begin
        masterStrobe = (mdiv_ff == 8'(MASTER_DIV - 1));
        nxt_mdiv = masterStrobe ? 8'h00 : mdiv_ff + 8'h01;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            mdiv_ff <= 8'h00;
        end
        else
        begin
            mdiv_ff <= nxt_mdiv;
        end
    end

    divide_by_ten_stage #(.DIVIDE(TICK_DIVIDE)) i_divide_by_ten_stage
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .strobeIn(masterStrobe),
        .tickOut(timerTick) // (R16)
    );

    timer_host_port i_timer_host_port
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .ioWrite(ioWrite),
        .ioAddr(ioAddr),
        .ioData(ioData),
        .cmdWrite(cmdWrite),
        .cmdCode(cmdCode),
        .lowByte(lowByte),
        .highByte(highByte),
        .lengthWrite(lengthWrite)
    );

    // ----------------------------------------
    // length rewrite, applied once the high byte has landed
    // ----------------------------------------
    logic lenUpdate_ff;
    logic nxt_lenUpdate;

    always_comb
    begin
        nxt_lenUpdate = lengthWrite;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            lenUpdate_ff <= 1'b0;
        end
        else
        begin
            lenUpdate_ff <= nxt_lenUpdate;
        end
    end

    // ----------------------------------------
    // counter state
    // ----------------------------------------
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;
    logic [WIDTH-1:0] length_ff;
    logic [WIDTH-1:0] nxt_length;
    wave_mode_t wave_ff;
    wave_mode_t nxt_wave;
    logic run_ff;
    logic nxt_run;
    logic stopAtTc_ff;
    logic nxt_stopAtTc;
    logic pendStart_ff;
    logic nxt_pendStart;
    logic out_ff;
    logic nxt_out;
    logic [WIDTH-1:0] progLength;
    wave_mode_t progWave;
    logic terminal;
    logic [WIDTH-1:0] half;

    // ----------------------------------------
    // wave decoding
    // ----------------------------------------
    function automatic logic is_square_wave(input wave_mode_t mode);
        return mode == WAVE_SINGLE_SQUARE || mode == WAVE_CONT_SQUARE;
    endfunction : is_square_wave

    function automatic logic is_pulse_wave(input wave_mode_t mode);
        return mode == WAVE_SINGLE_PULSE || mode == WAVE_RELOAD_PULSE;
    endfunction : is_pulse_wave

    assign progLength = {highByte[HIGH_COUNT_MSB:0], lowByte}; // (R20)
    assign progWave = wave_mode_t'(highByte[WAVE_MSB:WAVE_LSB]); // (R20)
    assign terminal = run_ff && timerTick && (count_ff == {{(WIDTH-1){1'b0}}, 1'b1});
    assign half = length_ff >> 1;

    always_comb
    begin
        nxt_count = count_ff;
        nxt_length = length_ff;
        nxt_wave = wave_ff;
        nxt_run = run_ff;
        nxt_stopAtTc = stopAtTc_ff;
        nxt_pendStart = pendStart_ff;
        nxt_out = out_ff;
        if (run_ff && timerTick)
        begin
            nxt_count = count_ff - {{(WIDTH-1){1'b0}}, 1'b1}; // (R1)
            if (is_square_wave(wave_ff))
            begin
                if (count_ff == half + {{(WIDTH-1){1'b0}}, 1'b1})
                begin
                    nxt_out = 1'b0; // (R7)
                end
            end
        end
        if (terminal)
        begin
            nxt_out = 1'b0;
            nxt_count = length_ff;
            if (is_pulse_wave(wave_ff))
            begin
                nxt_out = 1'b1; // (R15)
            end
            if (wave_ff == WAVE_CONT_SQUARE)
            begin
                nxt_out = 1'b1; // (R8)
            end
            if (wave_ff == WAVE_SINGLE_SQUARE || wave_ff == WAVE_SINGLE_PULSE)
            begin
                nxt_run = 1'b0; // (R9) (R18)
            end
            if (stopAtTc_ff)
            begin
                nxt_run = 1'b0; // (R5)
                nxt_stopAtTc = 1'b0;
            end
            if (pendStart_ff)
            begin
                // deferred start takes the programmed values
                nxt_length = progLength; // (R6)
                nxt_wave = progWave;
                nxt_count = progLength;
                nxt_run = 1'b1;
                nxt_pendStart = 1'b0;
                nxt_stopAtTc = 1'b0;
                nxt_out = 1'b1;
            end
        end
        else if (run_ff && timerTick && out_ff && is_pulse_wave(wave_ff))
        begin
            nxt_out = 1'b0; // (R10)
        end
        if (!run_ff && (wave_ff == WAVE_SINGLE_PULSE) && timerTick)
        begin
            nxt_out = 1'b0;
        end
        if (lenUpdate_ff && run_ff)
        begin
            nxt_length = progLength; // (R14)
        end
        if (cmdWrite)
        begin
            case (timer_cmd_t'(cmdCode))
                CMD_NOP:
                begin
                    nxt_run = nxt_run; // (R3)
                end
                CMD_STOP:
                begin
                    if (run_ff)
                    begin
                        nxt_run = 1'b0; // (R4)
                        nxt_pendStart = 1'b0;
                        nxt_stopAtTc = 1'b0;
                    end
                end
                CMD_STOP_AT_TC:
                begin
                    if (run_ff)
                    begin
                        nxt_stopAtTc = 1'b1; // (R5)
                    end
                end
                CMD_START:
                begin
                    if (run_ff)
                    begin
                        nxt_pendStart = 1'b1; // (R6)
                    end
                    else
                    begin
                        nxt_length = progLength; // (R6)
                        nxt_wave = progWave;
                        nxt_count = progLength;
                        nxt_run = 1'b1;
                        nxt_out = is_square_wave(progWave);
                    end
                end
                default:
                begin
                    nxt_run = nxt_run;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            count_ff <= COUNT_RESET; // (R21)
            length_ff <= COUNT_RESET;
            wave_ff <= WAVE_SINGLE_SQUARE;
            run_ff <= 1'b0;
            stopAtTc_ff <= 1'b0;
            pendStart_ff <= 1'b0;
            out_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            length_ff <= nxt_length;
            wave_ff <= nxt_wave;
            run_ff <= nxt_run;
            stopAtTc_ff <= nxt_stopAtTc;
            pendStart_ff <= nxt_pendStart;
            out_ff <= nxt_out;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign timerOut = out_ff;
    assign timerInterrupt = out_ff; // (R15)
    assign speakerDrive = out_ff & processor_serial_out_bit; // (R17)
    assign running = run_ff;
    assign currentCount = count_ff; // (R15)
endmodule : programmable_interval_timer
`default_nettype wire

// [sim/programmable_interval_timer_properties.sv]
// port checker for the interval timer
`default_nettype none
module programmable_interval_timer_properties
    import interval_timer_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ioWrite,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioData,
    input wire logic processor_serial_out_bit,
    input wire logic timerOut,
    input wire logic timerInterrupt,
    input wire logic speakerDrive,
    input wire logic running,
    input wire logic [WIDTH-1:0] currentCount
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lowLen_ff;
    logic [7:0] highLen_ff;
    logic cmdHit;
    logic startIdle;
    assign cmdHit = ioWrite && ioAddr == ADDR_TIMER_COMMAND;
    assign startIdle = cmdHit && ioData[7:6] == 2'h3 && !running;
    // ----
    // shadow of the length bytes
    // ----
    always_ff @(posedge sys_clk)
    begin
        if (ioWrite && ioAddr == ADDR_COUNT_LOW)
            lowLen_ff <= ioData;
        if (ioWrite && ioAddr == ADDR_COUNT_HIGH_WAVE)
            highLen_ff <= ioData;
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    property p_reset;
        disable iff (1'b0) reset |=> !running && !timerOut && currentCount == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not clear");
    property p_start;
        startIdle |=> running && currentCount == {highLen_ff[5:0], lowLen_ff};
    endproperty
    a_start: assert property (p_start) else $error("start load wrong");
    property p_stop;
        cmdHit && ioData[7:6] == 2'h1 |=> !running;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    property p_idle;
        !running && !startIdle |=> !running;
    endproperty
    a_idle: assert property (p_idle) else $error("idle timer started");
    property p_speaker;
        speakerDrive == (timerOut && processor_serial_out_bit);
    endproperty
    a_speaker: assert property (p_speaker) else $error("speaker gate wrong");
    property p_irq;
        timerInterrupt == timerOut;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt differs");
    property p_down;
        running && $past(running) && $changed(currentCount) |->
            currentCount == $past(currentCount) - 1'b1 || $past(currentCount) == 14'h0001;
    endproperty
    a_down: assert property (p_down) else $error("count step wrong");
    property p_tick;
        running && $past(running) && $changed(currentCount) |=> $stable(currentCount)[*8];
    endproperty
    a_tick: assert property (p_tick) else $error("tick too fast");
endmodule : programmable_interval_timer_properties
bind programmable_interval_timer programmable_interval_timer_properties #(.WIDTH(WIDTH))
    i_props (.sys_clk(sys_clk), .reset(reset), .ioWrite(ioWrite), .ioAddr(ioAddr),
    .ioData(ioData), .processor_serial_out_bit(processor_serial_out_bit),
    .timerOut(timerOut), .timerInterrupt(timerInterrupt), .speakerDrive(speakerDrive),
    .running(running), .currentCount(currentCount));
`default_nettype wire

// [sim/io_host_model.sv]
// host processor model: byte writes on the timer bus
`default_nettype none
module io_host_model
    import interval_timer_pkg::*;
(
    input wire logic sys_clk,
    output logic ioWrite,
    output logic [7:0] ioAddr,
    output logic [7:0] ioData
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        ioWrite = 1'b0;
        ioAddr = 8'h00;
        ioData = 8'h00;
    end
    // ----
    // one strobe, lines inverted after it
    // ----
    task put(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        ioWrite = 1'b1;
        ioAddr = addr;
        ioData = data;
        @(posedge sys_clk);
        @(negedge sys_clk);
        ioWrite = 1'b0;
        ioAddr = ~addr;
        ioData = ~data;
    endtask : put
    task setup(input logic [13:0] len, input logic [1:0] wave, input logic [1:0] cmd);
        repeat (10) @(negedge sys_clk);
        put(ADDR_COUNT_LOW, len[7:0]);
        put(ADDR_COUNT_HIGH_WAVE, {wave, len[13:8]});
        put(ADDR_TIMER_COMMAND, {cmd, 6'h00});
    endtask : setup
endmodule : io_host_model
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the interval timer
`default_nettype none
module testbench;
    import interval_timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic serialBit = 1'b0;
    wire logic ioWrite;
    wire logic [7:0] ioAddr;
    wire logic [7:0] ioData;
    logic timerOut;
    logic timerInterrupt;
    logic speakerDrive;
    logic running;
    logic [13:0] currentCount;
    int bad_count = 0;
    int compares = 0;
    always #2 sys_clk = ~sys_clk;
    io_host_model i_io_host_model (.sys_clk(sys_clk), .ioWrite(ioWrite), .ioAddr(ioAddr),
        .ioData(ioData));
    programmable_interval_timer #(.MASTER_DIV(1)) i_programmable_interval_timer
        (.sys_clk(sys_clk), .reset(reset), .ioWrite(ioWrite), .ioAddr(ioAddr),
        .ioData(ioData), .processor_serial_out_bit(serialBit), .timerOut(timerOut),
        .timerInterrupt(timerInterrupt), .speakerDrive(speakerDrive), .running(running),
        .currentCount(currentCount));
    // ----
    // checks and waits
    // ----
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function logic pick(input int which);
        return which == 0 ? timerOut : which == 1 ? running : currentCount == 14'h0005;
    endfunction : pick
    task wait_for(input int which, input logic val, input int lim);
        int n;
        n = 0;
        while (pick(which) !== val && n < lim)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk({15'h0000, pick(which)}, {15'h0000, val});
    endtask : wait_for
    task end_sim;
        $display("compares=%0d bad=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    initial
    begin
        #60000;
        bad_count++;
        end_sim();
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        chk({14'h0000, running, timerOut}, 16'h0000);
        chk({2'h0, currentCount}, 16'h0000);
        $display("test reset done");
        serialBit = 1'b1;
        i_io_host_model.setup(14'h0103, WAVE_SINGLE_PULSE, CMD_START);
        chk({2'h0, currentCount}, 16'h0103);
        chk({14'h0000, running, timerOut}, 16'h0002);
        wait_for(0, 1'b1, 2800);
        chk({14'h0000, speakerDrive, timerInterrupt}, 16'h0003);
        serialBit = 1'b0;
        #1;
        chk({15'h0000, speakerDrive}, 16'h0000);
        wait_for(1, 1'b0, 20);
        wait_for(0, 1'b0, 20);
        repeat (40) @(negedge sys_clk);
        chk({15'h0000, running}, 16'h0000);
        $display("test single pulse done");
        i_io_host_model.setup(14'h0006, WAVE_SINGLE_SQUARE, CMD_START);
        chk({15'h0000, timerOut}, 16'h0001);
        wait_for(0, 1'b0, 70);
        chk({15'h0000, currentCount <= 14'h0004}, 16'h0001);
        wait_for(1, 1'b0, 70);
        $display("test half square done");
        i_io_host_model.setup(14'h0003, WAVE_RELOAD_PULSE, CMD_START);
        wait_for(0, 1'b1, 50);
        wait_for(0, 1'b0, 20);
        chk({15'h0000, running}, 16'h0001);
        i_io_host_model.put(ADDR_COUNT_LOW, 8'h05);
        i_io_host_model.put(ADDR_COUNT_HIGH_WAVE, 8'hC0);
        wait_for(2, 1'b1, 60);
        i_io_host_model.put(ADDR_TIMER_COMMAND, 8'h00);
        chk({15'h0000, running}, 16'h0001);
        i_io_host_model.put(ADDR_TIMER_COMMAND, 8'h40);
        chk({15'h0000, running}, 16'h0000);
        $display("test reload and stop done");
        i_io_host_model.setup(14'h0004, WAVE_CONT_SQUARE, CMD_START);
        repeat (60) @(negedge sys_clk);
        chk({15'h0000, running}, 16'h0001);
        wait_for(0, 1'b1, 50);
        wait_for(0, 1'b0, 50);
        wait_for(0, 1'b1, 50);
        i_io_host_model.put(ADDR_TIMER_COMMAND, 8'h80);
        wait_for(1, 1'b0, 60);
        i_io_host_model.put(ADDR_TIMER_COMMAND, 8'hC0);
        chk({15'h0000, running}, 16'h0001);
        i_io_host_model.put(ADDR_COUNT_LOW, 8'h07);
        i_io_host_model.put(ADDR_COUNT_HIGH_WAVE, 8'h80);
        i_io_host_model.put(ADDR_TIMER_COMMAND, 8'hC0);
        chk({15'h0000, running}, 16'h0001);
        wait_for(1, 1'b0, 300);
        chk({2'h0, currentCount}, 16'h0007);
        i_io_host_model.put(ADDR_TIMER_COMMAND, 8'h40);
        i_io_host_model.put(ADDR_TIMER_COMMAND, 8'h80);
        i_io_host_model.put(8'h11, 8'hC0);
        chk({15'h0000, running}, 16'h0000);
        $display("test square and idle done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
